// ---- pkg/cca_regs.vh ----
/*
 * Register offsets, field positions, reset values and timing counts
 * of the counter array core. Assumes a 32-bit classic bus slave whose
 * byte registers sit in data bits 7:0.
 */
`ifndef CCA_REGS_VH
`define CCA_REGS_VH

// ============================================================
// Byte offsets
`define CCA_OFF_MODE 8'h00
`define CCA_OFF_CTRL 8'h04
`define CCA_OFF_PWM 8'h08
`define CCA_OFF_CNTL 8'h0C
`define CCA_OFF_CNTH 8'h10
`define CCA_REGION_MMODE 3'h1
`define CCA_REGION_CPL 3'h2
`define CCA_REGION_CPH 3'h3

// ============================================================
// Mode register fields
`define CCA_MODE_IDLE 7
`define CCA_MODE_WDU 6
`define CCA_MODE_TB_HI 3
`define CCA_MODE_TB_LO 1
`define CCA_MODE_OVIE 0
`define CCA_MODE_RST 8'h40

// Control register fields
`define CCA_CTRL_CF 7
`define CCA_CTRL_RUN 6

// Pulse control register fields
`define CCA_PWM_RELOAD_REGISTER_SELECT 7
`define CCA_PWM_INTERMEDIATE_OVERFLOW_FLAG 6
`define CCA_PWM_COVIE 5

// Module mode register fields
`define CCA_MM_PWM16 7
`define CCA_MM_ECOM 6
`define CCA_MM_CAPP 5
`define CCA_MM_CAPN 4
`define CCA_MM_MAT 3
`define CCA_MM_TOG 2
`define CCA_MM_PWM 1
`define CCA_MM_IE 0

// ============================================================
// Timebase codes and divider counts
`define CCA_TB_DIV12 3'h0
`define CCA_TB_DIV4 3'h1
`define CCA_TB_T0 3'h2
`define CCA_TB_EXT 3'h3
`define CCA_TB_SYS 3'h4
`define CCA_TB_OSC8 3'h5
`define CCA_TB_T4 3'h6
`define CCA_TB_T5 3'h7
`define CCA_DIV12_LAST 4'hB
`define CCA_DIV4_LAST 2'h3
`define CCA_OSC_LAST 3'h7

`endif

// ---- design/cca_core.v ----
/*
 * Counter array core: shared 16-bit counter with selectable timebase,
 * snapshot readout, overflow flags, six capture/compare modules and
 * a combined interrupt request, behind a classic Wishbone slave.
 * Assumes timer overflow pulses come from logic on sys_clk, and that
 * the pins (count input, oscillator, module lines) are asynchronous.
 */
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "cca_regs.vh"

module cca_core #(
    parameter NMOD = 6
) (
    input wire sys_clk,
    input wire srst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire cpu_idle,
    input wire timer0_ovf,
    input wire timer4_ovf,
    input wire timer5_ovf,
    input wire external_count_input,
    input wire ext_osc_in,
    input wire [NMOD-1:0] module_io_in,
    output reg [NMOD-1:0] module_io_out,
    output wire [NMOD-1:0] module_io_oe,
    output wire array_irq
);

// ============================================================
// Pin synchronisers: line NMOD is count input, NMOD+1 oscillator
localparam NP = NMOD + 2;
wire [NP-1:0] pin_raw = {ext_osc_in, external_count_input, module_io_in};
reg [NP-1:0] s1_r, s2_r, s3_r, lvl_r;
wire [NP-1:0] agree = ~(s2_r ^ s3_r);
wire [NP-1:0] rise = agree & s2_r & ~lvl_r;
wire [NP-1:0] fall = agree & ~s2_r & lvl_r;

always @(posedge sys_clk) begin
    if (srst) begin
        s1_r <= {NP{1'b0}};
        s2_r <= {NP{1'b0}};
        s3_r <= {NP{1'b0}};
        lvl_r <= {NP{1'b0}};
    end else begin
        s1_r <= pin_raw;
        s2_r <= s1_r;
        s3_r <= s2_r;
        // Level counts only once two stages agree; glitches shorter
        // than two clocks are dropped
        lvl_r <= (lvl_r & ~agree) | (s2_r & agree);
    end
end

// ============================================================
// Registers
reg [7:0] mode_r, ctrl_r, pwm_r, snap_r;
reg [15:0] cnt_r;
reg [8*NMOD-1:0] mm_r;
reg [16*NMOD-1:0] cap_r, rld_r;
reg [NMOD-1:0] mflag_r;
wire [NMOD-1:0] mev;

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = wb_req & wb_we_i & wb_sel_i[0];
wire rd = wb_req & ~wb_we_i;
wire [7:0] wd = wb_dat_i[7:0];
wire [2:0] region = wb_adr_i[7:5];
wire [2:0] midx = wb_adr_i[4:2];
wire wdu = mode_r[`CCA_MODE_WDU];
wire [2:0] tbsel = mode_r[`CCA_MODE_TB_HI:`CCA_MODE_TB_LO];
wire [1:0] clen = pwm_r[1:0];
wire reload_register_select = pwm_r[`CCA_PWM_RELOAD_REGISTER_SELECT];

// Module register hit, used by both the write and read paths
function hit;
    input [7:0] adr;
    input [2:0] reg_region;
    input [2:0] idx;
    begin
        hit = (adr[7:5] == reg_region) && (adr[4:2] == idx)
            && (adr[1:0] == 2'h0);
    end
endfunction

// ============================================================
// Timebase
reg [3:0] div12_r;
reg [1:0] div4_r;
reg [2:0] osc_r;
reg tick;
wire run = ctrl_r[`CCA_CTRL_RUN]
    & ~(cpu_idle & mode_r[`CCA_MODE_IDLE]);

always @* begin
    case (tbsel)
        `CCA_TB_DIV12: tick = (div12_r == `CCA_DIV12_LAST);
        `CCA_TB_DIV4: tick = (div4_r == `CCA_DIV4_LAST);
        `CCA_TB_T0: tick = timer0_ovf;
        `CCA_TB_EXT: tick = fall[NMOD];
        `CCA_TB_SYS: tick = 1'b1;
        `CCA_TB_OSC8: tick = rise[NMOD+1] & (osc_r == `CCA_OSC_LAST);
        `CCA_TB_T4: tick = timer4_ovf;
        default: tick = timer5_ovf;
    endcase
end

always @(posedge sys_clk) begin
    if (srst) begin
        div12_r <= 4'h0;
        div4_r <= 2'h0;
        osc_r <= 3'h0;
    end else begin
        div12_r <= (div12_r == `CCA_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
        div4_r <= div4_r + 2'h1;
        if (rise[NMOD+1])
            osc_r <= osc_r + 3'h1;
    end
end

// ============================================================
// Counter, overflows, snapshot
wire step = tick & run;
wire [10:0] nmask = 11'h7FF >> (2'h3 - clen);
wire wrap = step & (cnt_r == 16'hFFFF);
wire iovf = step & ((cnt_r[10:0] | ~nmask) == 11'h7FF);
reg step_d, wrap_d, iovf_d;
wire cnt_wr_ok = ~wdu;

always @(posedge sys_clk) begin
    if (srst) begin
        cnt_r <= 16'h0000;
        snap_r <= 8'h00;
        step_d <= 1'b0;
        wrap_d <= 1'b0;
        iovf_d <= 1'b0;
    end else begin
        step_d <= step;
        wrap_d <= wrap;
        iovf_d <= iovf;
        if (wr & cnt_wr_ok & (wb_adr_i == `CCA_OFF_CNTL))
            cnt_r[7:0] <= wd;
        else if (wr & cnt_wr_ok & (wb_adr_i == `CCA_OFF_CNTH))
            cnt_r[15:8] <= wd;
        else if (step)
            cnt_r <= cnt_r + 16'h0001;
        if (rd & (wb_adr_i == `CCA_OFF_CNTL))
            snap_r <= cnt_r[15:8];
    end
end

// ============================================================
// Control registers and flags; hardware set wins over a clear
always @(posedge sys_clk) begin
    if (srst) begin
        mode_r <= `CCA_MODE_RST;
        ctrl_r <= 8'h00;
        pwm_r <= 8'h00;
        mflag_r <= {NMOD{1'b0}};
    end else begin
        if (wr & (wb_adr_i == `CCA_OFF_MODE)) begin
            // While watchdog use holds, only its own clear is taken
            if (~wdu)
                mode_r <= wd;
            else
                mode_r[`CCA_MODE_WDU] <= wd[`CCA_MODE_WDU];
        end
        if (wr & (wb_adr_i == `CCA_OFF_CTRL))
            ctrl_r <= wd;
        if (wr & (wb_adr_i == `CCA_OFF_PWM))
            pwm_r <= wd;
        if (wrap_d)
            ctrl_r[`CCA_CTRL_CF] <= 1'b1;
        if (iovf_d)
            pwm_r[`CCA_PWM_INTERMEDIATE_OVERFLOW_FLAG] <= 1'b1;
        mflag_r <= (wr & (wb_adr_i == `CCA_OFF_CTRL) ? wd[NMOD-1:0]
            : mflag_r) | mev;
    end
end

// ============================================================
// Capture/compare modules
genvar i;
generate
for (i = 0; i < NMOD; i = i + 1) begin : g_mod
    localparam [2:0] IDX = i;
    wire [7:0] md = mm_r[8*i+7:8*i];
    wire [15:0] cap = cap_r[16*i+15:16*i];
    wire [15:0] rld = rld_r[16*i+15:16*i];
    wire nocap = (md[5:4] == 2'h0);
    wire capm = (md[3:1] == 3'h0) & ~nocap;
    wire swt = nocap & md[3] & ~md[2] & ~md[1];
    wire hso = nocap & md[3] & md[2] & ~md[1];
    wire frq = nocap & ~md[3] & md[2] & md[1];
    wire pwm = nocap & ~md[2] & md[1];
    wire pulse_mode_enable = pwm & ~md[`CCA_MM_PWM16];
    wire pwm16 = pwm & md[`CCA_MM_PWM16];
    wire ecom = md[`CCA_MM_ECOM];
    wire use_rld = pulse_mode_enable & (clen != 2'h0) & reload_register_select;
    wire m16 = step_d & (cnt_r == cap);
    wire mn = step_d & ((cnt_r[10:0] & nmask) == (cap[10:0] & nmask));
    wire m8 = step_d & (cnt_r[7:0] == cap[7:0]);
    wire cedge = capm & ((rise[i] & md[`CCA_MM_CAPP])
        | (fall[i] & md[`CCA_MM_CAPN]));
    wire wl = wr & ~(wdu & (i == NMOD - 1))
        & hit(wb_adr_i, `CCA_REGION_CPL, IDX);
    wire wh = wr & ~(wdu & (i == NMOD - 1))
        & hit(wb_adr_i, `CCA_REGION_CPH, IDX);
    wire wm = wr & ~(wdu & (i == NMOD - 1))
        & hit(wb_adr_i, `CCA_REGION_MMODE, IDX);

    assign mev[i] = cedge
        | ((swt | hso) & ecom & md[`CCA_MM_MAT] & m16)
        | (frq & md[`CCA_MM_MAT] & m16)
        | (pulse_mode_enable & ecom & md[`CCA_MM_MAT] & mn)
        | (pwm16 & ecom & md[`CCA_MM_MAT] & m16);
    assign module_io_oe[i] = hso | frq | pwm;

    always @(posedge sys_clk) begin
        if (srst) begin
            mm_r[8*i+7:8*i] <= 8'h00;
            cap_r[16*i+15:16*i] <= 16'h0000;
            rld_r[16*i+15:16*i] <= 16'h0000;
            module_io_out[i] <= 1'b0;
        end else begin
            if (wm)
                mm_r[8*i+7:8*i] <= wd;
            else if (wl)
                mm_r[8*i+`CCA_MM_ECOM] <= 1'b0;
            else if (wh)
                mm_r[8*i+`CCA_MM_ECOM] <= 1'b1;
            if (cedge)
                cap_r[16*i+15:16*i] <= cnt_r;
            else if (wl & use_rld)
                rld_r[16*i+7:16*i] <= wd;
            else if (wh & use_rld)
                rld_r[16*i+15:16*i+8] <= wd;
            else if (wl)
                cap_r[16*i+7:16*i] <= wd;
            else if (wh)
                cap_r[16*i+15:16*i+8] <= wd;
            else if (frq & ecom & m8)
                cap_r[16*i+7:16*i] <= cap[7:0] + cap[15:8];
            else if (pulse_mode_enable & iovf_d)
                // 8-bit reloads low from high; longer modes from reload
                cap_r[16*i+15:16*i] <= (clen == 2'h0)
                    ? {cap[15:8], cap[15:8]} : rld;
            if ((hso & m16 | frq & m8) & ecom)
                module_io_out[i] <= ~module_io_out[i];
            else if (pwm & ~ecom)
                module_io_out[i] <= 1'b0;
            else if (pulse_mode_enable & mn | pwm16 & m16)
                module_io_out[i] <= 1'b1;
            else if (pulse_mode_enable & iovf_d | pwm16 & wrap_d)
                module_io_out[i] <= 1'b0;
        end
    end
end
endgenerate

// ============================================================
// Interrupt request, enabled per source
wire [NMOD-1:0] mie;
generate
for (i = 0; i < NMOD; i = i + 1) begin : g_ie
    assign mie[i] = mm_r[8*i+`CCA_MM_IE];
end
endgenerate

assign array_irq = (ctrl_r[`CCA_CTRL_CF] & mode_r[`CCA_MODE_OVIE])
    | (pwm_r[`CCA_PWM_INTERMEDIATE_OVERFLOW_FLAG] & pwm_r[`CCA_PWM_COVIE])
    | (|(mflag_r & mie));

// ============================================================
// Bus read path and acknowledge; one wait state, data registered
reg [7:0] rdata;
integer k;
always @* begin
    rdata = 8'h00;
    case (wb_adr_i)
        `CCA_OFF_MODE: rdata = mode_r;
        `CCA_OFF_CTRL: rdata = {ctrl_r[7:6], mflag_r};
        `CCA_OFF_PWM: rdata = pwm_r;
        `CCA_OFF_CNTL: rdata = cnt_r[7:0];
        `CCA_OFF_CNTH: rdata = snap_r;
        default: rdata = 8'h00;
    endcase
    for (k = 0; k < NMOD; k = k + 1) begin
        if (hit(wb_adr_i, `CCA_REGION_MMODE, k[2:0]))
            rdata = mm_r[8*k+:8];
        if (hit(wb_adr_i, `CCA_REGION_CPL, k[2:0]))
            rdata = (g_sel(k) ? rld_r[16*k+:8] : cap_r[16*k+:8]);
        if (hit(wb_adr_i, `CCA_REGION_CPH, k[2:0]))
            rdata = (g_sel(k) ? rld_r[16*k+8+:8] : cap_r[16*k+8+:8]);
    end
end

// Reload view is selected the same way for reads as for writes
function g_sel;
    input integer idx;
    begin
        g_sel = mm_r[8*idx+1] & ~mm_r[8*idx+7] & ~mm_r[8*idx+2]
            & (mm_r[8*idx+5 -: 2] == 2'h0) & (clen != 2'h0) & reload_register_select;
    end
endfunction

always @(posedge sys_clk) begin
    if (srst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= wb_req;
        if (rd)
            wb_dat_o <= {24'h00_0000, rdata};
    end
end

endmodule // cca_core
`default_nettype wire

// ---- sim/cca_core_asserts.sv ----
/* Port checker for cca_core.
   Assumes a classic bus master per the hand-over. */
`timescale 1ns/10ps
`default_nettype none
`include "cca_regs.vh"
// ====================================
// Checker
module cca_core_asserts #(
    parameter NMOD = 6
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NMOD-1:0] module_io_out,
    input wire logic [NMOD-1:0] module_io_oe,
    input wire logic array_irq
);
    logic cf_seen_r;
    logic mode_wr_r;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_ack = wb_ack_o && !wb_we_i;
    // Last overflow flag seen by a read; any control write forgets it
    always @(posedge sys_clk) begin
        if (srst) begin
            cf_seen_r <= 1'b0;
            mode_wr_r <= 1'b0;
        end else if (wb_ack_o) begin
            if (wb_adr_i == `CCA_OFF_CTRL)
                cf_seen_r <= !wb_we_i && wb_dat_o[`CCA_CTRL_CF];
            if (wb_adr_i == `CCA_OFF_MODE && wb_we_i)
                mode_wr_r <= 1'b1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_req;
        take;
    endsequence
    sequence s_ack;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_req |-> s_ack)
        else $error("ack not a single pulse after request");
    AST_ACK_CAUSE: assert property (!take |=> !wb_ack_o)
        else $error("ack without request");
    AST_RST_QUIET: assert property ($fell(srst) |-> !wb_ack_o && !array_irq
        && module_io_oe == '0 && module_io_out == '0)
        else $error("outputs active after reset");
    AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_DAT_HOLD: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data moved without read");
    AST_CF_HELD: assert property (
        rd_ack && wb_adr_i == `CCA_OFF_CTRL && cf_seen_r
        |-> wb_dat_o[`CCA_CTRL_CF]) else $error("overflow flag lost");
    AST_WDU_RESET: assert property (
        rd_ack && wb_adr_i == `CCA_OFF_MODE && !mode_wr_r
        |-> wb_dat_o[7:0] == `CCA_MODE_RST) else $error("mode reset wrong");
    AST_IRQ_FALL: assert property (
        $fell(array_irq) |-> wb_ack_o && wb_we_i)
        else $error("irq fell without write");
endmodule // cca_core_asserts
bind cca_core cca_core_asserts #(.NMOD(NMOD)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .module_io_out(module_io_out), .module_io_oe(module_io_oe),
    .array_irq(array_irq)
);
`default_nettype wire

// ---- sim/cca_pin_model.sv ----
/* Pin side of cca_core: timer pulses, count input, oscillator, lines.
   Assumes the bench picks module line levels. */
`timescale 1ns/10ps
`default_nettype none
// ====================================
// Pin model
module cca_pin_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [5:0] line_req,
    input wire logic [5:0] module_io_out,
    input wire logic [5:0] module_io_oe,
    output logic timer0_ovf,
    output logic timer4_ovf,
    output logic timer5_ovf,
    output logic external_count_input,
    output logic ext_osc_in,
    output logic [5:0] module_io_in
);
    int unsigned tick_r;
    logic [5:0] held_r;
    always @(posedge sys_clk) begin
        tick_r <= srst ? 0 : tick_r + 1;
        held_r <= line_req;
    end
    // Distinct rates so a wrong timebase code shows in the count
    assign timer0_ovf = (tick_r % 5) == 0;
    assign timer4_ovf = (tick_r % 7) == 0;
    assign timer5_ovf = (tick_r % 9) == 0;
    assign external_count_input = (tick_r % 6) < 3;
    assign ext_osc_in = tick_r[1];
    assign module_io_in = (module_io_oe & module_io_out)
        | (~module_io_oe & held_r);
endmodule // cca_pin_model
`default_nettype wire

// ---- sim/cca_core_test.sv ----
/* Bench for cca_core.
   Assumes the pin model and the register header. */
`timescale 1ns/10ps
`default_nettype none
`include "cca_regs.vh"
`define CHK(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("ERROR %0t: got %h want %h", $time, g, e); \
    end \
end
// ====================================
// Bench
module cca_core_test;
    logic sys_clk;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, cpu_idle = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o, seed, v, u;
    logic wb_ack_o, array_irq, timer0_ovf, timer4_ovf, timer5_ovf;
    logic external_count_input, ext_osc_in;
    logic [5:0] module_io_in, module_io_out, module_io_oe;
    logic [5:0] line_req = 6'h00;
    logic global_irq_enable = 1'b1, array_irq_enable = 1'b1;
    logic irq_taken;
    // Processor only takes the request with both enables set
    assign irq_taken = array_irq & global_irq_enable & array_irq_enable;
    logic [15:0] ent;
    logic [7:0] e;
    logic [15:0] exp_q[$];
    int num_errors = 0;
    int cmp_count = 0;
    int dv[8] = '{12, 4, 5, 6, 1, 32, 7, 9};
    cca_core #(.NMOD(6)) DUT (
        .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cpu_idle(cpu_idle), .timer0_ovf(timer0_ovf),
        .timer4_ovf(timer4_ovf), .timer5_ovf(timer5_ovf),
        .external_count_input(external_count_input),
        .ext_osc_in(ext_osc_in), .module_io_in(module_io_in),
        .module_io_out(module_io_out), .module_io_oe(module_io_oe),
        .array_irq(array_irq)
    );
    cca_pin_model u_pins (
        .sys_clk(sys_clk), .srst(srst), .line_req(line_req),
        .module_io_out(module_io_out), .module_io_oe(module_io_oe),
        .timer0_ovf(timer0_ovf), .timer4_ovf(timer4_ovf),
        .timer5_ovf(timer5_ovf), .ext_osc_in(ext_osc_in),
        .external_count_input(external_count_input),
        .module_io_in(module_io_in)
    );
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1)
            num_errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    // Notes the accepted byte range; the monitor checks it
    task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        exp_q.push_back({lo, hi});
        xfer(1'b0, a, 8'h00);
    endtask
    task automatic report_and_stop();
        if (exp_q.size() != 0)
            num_errors++;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            ent = exp_q.pop_front();
            `CHK(wb_dat_o[7:0] >= ent[15:8] && wb_dat_o[7:0] <= ent[7:0], 1'b1)
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        seed = 32'h000119F8;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rd(`CCA_OFF_MODE, 8'h40, 8'h40);
        wr(`CCA_OFF_CNTL, 8'h55);
        rd(`CCA_OFF_CNTL, 8'h00, 8'h00);
        wr(`CCA_OFF_MODE, 8'h0F);
        rd(`CCA_OFF_MODE, 8'h00, 8'h00);
        wr(8'hFC, 8'hFF);
        rd(8'hFC, 8'h00, 8'h00);
        wr(`CCA_OFF_CNTH, 8'h34);
        wr(`CCA_OFF_CNTL, 8'h56);
        rd(`CCA_OFF_CNTL, 8'h56, 8'h56);
        wr(`CCA_OFF_CNTH, 8'h78);
        rd(`CCA_OFF_CNTH, 8'h34, 8'h34);
        for (int c = 0; c < 8; c++) begin
            v = rnd();
            cpu_idle <= v[0];
            wr(`CCA_OFF_MODE, {4'h0, c[2:0], 1'b0});
            wr(`CCA_OFF_CNTL, 8'h00);
            wr(`CCA_OFF_CNTH, 8'h00);
            wr(`CCA_OFF_CTRL, 8'h40);
            repeat (240) @(posedge sys_clk);
            wr(`CCA_OFF_CTRL, 8'h00);
            rd(`CCA_OFF_CNTL, 8'(240 / dv[c] - 1), 8'(246 / dv[c] + 1));
            rd(`CCA_OFF_CNTH, 8'h00, 8'h00);
        end
        wr(`CCA_OFF_MODE, 8'h08);
        wr(`CCA_OFF_CNTL, 8'hF0);
        wr(`CCA_OFF_CNTH, 8'hFF);
        wr(`CCA_OFF_CTRL, 8'h40);
        repeat (30) @(posedge sys_clk);
        rd(`CCA_OFF_CTRL, 8'hC0, 8'hC0);
        `CHK(array_irq, 1'b0)
        wr(`CCA_OFF_MODE, 8'h09);
        `CHK(array_irq, 1'b1)
        rd(`CCA_OFF_CTRL, 8'hC0, 8'hC0);
        wr(`CCA_OFF_CTRL, 8'h00);
        `CHK(array_irq, 1'b0)
        wr(`CCA_OFF_MODE, 8'h08);
        // Second start sits one bit lower: no carry out of the chosen bit
        for (int n = 0; n < 4; n++) begin
            for (int k = 0; k < 2; k++) begin
                e = {1'b0, k == 0, 1'b1, 3'h0, n[1:0]};
                v = (32'h1 << (8 + n - k)) - 32'h8;
                wr(`CCA_OFF_PWM, e & 8'hBF);
                wr(`CCA_OFF_CNTL, v[7:0]);
                wr(`CCA_OFF_CNTH, v[15:8]);
                wr(`CCA_OFF_CTRL, 8'h40);
                repeat (20) @(posedge sys_clk);
                wr(`CCA_OFF_CTRL, 8'h00);
                rd(`CCA_OFF_PWM, e, e);
                `CHK(array_irq, e[6])
            end
        end
        wr(`CCA_OFF_PWM, 8'h00);
        for (int c = 0; c < 2; c++) begin
            v = rnd();
            wr(`CCA_OFF_CNTL, v[7:0]);
            wr(`CCA_OFF_CNTH, v[15:8]);
            if (c == 0) begin
                u = v;
                wr(8'h20, 8'h21);
                wr(8'h24, 8'h11);
                wr(8'h28, 8'h31);
            end
            line_req <= c ? 6'h00 : 6'h07;
            repeat (8) @(posedge sys_clk);
            e = c ? 8'h07 : 8'h05;
            rd(`CCA_OFF_CTRL, e, e);
            rd(8'h48, v[7:0], v[7:0]);
            rd(8'h68, v[15:8], v[15:8]);
            `CHK(array_irq, 1'b1)
            `CHK(irq_taken, 1'b1)
        end
        rd(8'h40, u[7:0], u[7:0]);
        rd(8'h44, v[7:0], v[7:0]);
        wr(8'h2C, 8'h48);
        wr(8'h4C, 8'h00);
        rd(8'h2C, 8'h08, 8'h08);
        wr(8'h6C, 8'h00);
        rd(8'h2C, 8'h48, 8'h48);
        wr(8'h30, 8'h46);
        `CHK(module_io_oe[4], 1'b1)
        wr(8'h30, 8'h02);
        wr(`CCA_OFF_CTRL, 8'h40);
        repeat (300) @(posedge sys_clk);
        `CHK(module_io_out[4], 1'b0)
        report_and_stop();
    end
endmodule // cca_core_test
`default_nettype wire
